// [hdl/frss_ctrl.sv]
// frss_ctrl: host-side controller for reset, suspend/resume and ready polling
// of an asynchronous multi-partition flash; pins are sampled on i_clk.
// Contract
// - hold reset low at least 100 ns for a guaranteed read-time reset.
// - at power-up keep reset low 100 ns after supply is stable.
// - leave 500 us between erase resume and the next erase suspend.
// - without status-read timing, poll the global ready bit instead.
// - later falling strobe opens a write, earlier rising strobe closes it.
`include "frss_consts.svh"
`default_nettype none
module frss_ctrl #(
   parameter longint PARAM_ERS_CYC = `FRSS_PARAM_ERS_S * `FRSS_CYC_PER_S,
   parameter longint MAIN_ERS_CYC  = `FRSS_MAIN_ERS_S * `FRSS_CYC_PER_S,
   parameter longint CHIP_ERS_CYC  = longint'(`FRSS_CHIP_ERS_S) * `FRSS_CYC_PER_S,
   parameter longint PROGRAM_CYC   = `FRSS_MAIN_ERS_S * `FRSS_CYC_PER_S,
   parameter longint RST_DONE_CYC  = `FRSS_RST_DONE_CYC,
   parameter longint RESUME_GAP_CYC = `FRSS_RESUME_GAP_CYC
) (
   // clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   // user request port
   input  wire logic                  i_req_valid,
   input  wire frss_pkg::frss_req_type i_req,
   output logic                       o_req_ready,
   output logic                       o_done,
   output logic                       o_timeout,
   output logic [15:0]                o_status,
   // flash pins
   output var frss_pkg::frss_pins_type o_pins,
   input  wire logic [15:0]           i_dq
);
   import frss_pkg::*;

   localparam int TW = 34;

   typedef enum logic [3:0] {
      S_POWERUP, S_RECOVER, S_IDLE, S_WR_LOW, S_WR_HIGH, S_RD_LOW, S_RD_SAMPLE,
      S_RD_GAP, S_RST_LOW, S_RST_WAIT
   } frss_state_type;

   frss_state_type state_reg;
   frss_req_type   req_reg;
   logic           polling_reg;
   logic           suspend_wait_reg;
   logic [7:0]     step_reg;
   logic           tmr_load;
   logic [TW-1:0]  tmr_count;
   logic           tmr_done;
   logic           gap_load;
   logic           gap_done;

   // ready bit chosen by the request; global covers engine busy elsewhere
   function automatic logic ready_of(input logic [15:0] sw, input logic glob);
      ready_of = glob ? sw[`FRSS_BIT_GLOBAL_READY] : sw[`FRSS_BIT_PART_READY];
   endfunction : ready_of

   function automatic logic [TW-1:0] limit_of(input frss_wait_type k);
      case (k)
         FRSS_WAIT_PARAM_ERS: limit_of = TW'(PARAM_ERS_CYC);
         FRSS_WAIT_MAIN_ERS:  limit_of = TW'(MAIN_ERS_CYC);
         FRSS_WAIT_CHIP_ERS:  limit_of = TW'(CHIP_ERS_CYC);
         default:             limit_of = TW'(PROGRAM_CYC);
      endcase
   endfunction : limit_of

   frss_timer #(.WIDTH(TW)) u_op_timer (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_load  (tmr_load),
      .i_count (tmr_count),
      .o_done  (tmr_done)
   );

   // resume-to-suspend spacing runs independently of the operation timer
   frss_timer #(.WIDTH(TW)) u_gap_timer (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_load  (gap_load),
      .i_count (TW'(RESUME_GAP_CYC)),
      .o_done  (gap_done)
   );

   wire logic accept = (state_reg == S_IDLE) && i_req_valid &&
                       !(i_req.op == FRSS_OP_SUSPEND_ERS && !gap_done);

   always_comb begin
      tmr_load  = 1'b0;
      tmr_count = '0;
      gap_load  = 1'b0;
      case (state_reg)
         S_IDLE: begin
            if (accept) begin
               case (i_req.op)
                  FRSS_OP_RESET: begin
                     tmr_load  = 1'b1;
                     tmr_count = TW'(`FRSS_RST_LOW_CYC);
                  end
                  FRSS_OP_POLL: begin
                     tmr_load  = 1'b1;
                     tmr_count = limit_of(i_req.wait_kind);
                  end
                  FRSS_OP_SUSPEND_PGM: begin
                     tmr_load  = 1'b1;
                     tmr_count = TW'(`FRSS_PGM_SUSP_CYC);
                  end
                  FRSS_OP_SUSPEND_ERS: begin
                     tmr_load  = 1'b1;
                     tmr_count = TW'(`FRSS_ERS_SUSP_CYC);
                  end
                  FRSS_OP_RESUME: begin
                     gap_load  = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
         S_RST_LOW: begin
            if (tmr_done) begin
               tmr_load  = 1'b1;
               tmr_count = TW'(RST_DONE_CYC);
            end
         end
         default: begin
         end
      endcase
   end

   // main sequencer
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg        <= S_POWERUP;
         req_reg          <= '0;
         polling_reg      <= 1'b0;
         suspend_wait_reg <= 1'b0;
         step_reg         <= '0;
      end else begin
         case (state_reg)
            S_POWERUP: begin
               // reset stays low from power-up for the minimum low time
               step_reg <= step_reg + 8'h01;
               if (step_reg >= 8'(`FRSS_RST_LOW_CYC)) begin
                  state_reg <= S_RECOVER;
                  step_reg  <= '0;
               end
            end
            S_RECOVER: begin
               step_reg <= step_reg + 8'h01;
               if (step_reg >= 8'(`FRSS_RECOVER_CYC)) begin
                  state_reg <= S_IDLE;
                  step_reg  <= '0;
               end
            end
            S_IDLE: begin
               if (accept) begin
                  req_reg <= i_req;
                  case (i_req.op)
                     FRSS_OP_RESET: state_reg <= S_RST_LOW;
                     FRSS_OP_POLL: begin
                        polling_reg <= 1'b1;
                        state_reg   <= S_WR_LOW;
                     end
                     FRSS_OP_NONE: state_reg <= S_IDLE;
                     default: begin
                        suspend_wait_reg <= (i_req.op == FRSS_OP_SUSPEND_PGM) ||
                                            (i_req.op == FRSS_OP_SUSPEND_ERS);
                        state_reg        <= S_WR_LOW;
                     end
                  endcase
               end
            end
            S_WR_LOW: begin
               state_reg <= S_WR_HIGH;
            end
            S_WR_HIGH: begin
               if (polling_reg || suspend_wait_reg) begin
                  state_reg <= S_RD_LOW;
               end else begin
                  state_reg <= S_IDLE;
               end
            end
            S_RD_LOW: begin
               state_reg <= S_RD_SAMPLE;
            end
            S_RD_SAMPLE: begin
               if (ready_of(i_dq, req_reg.use_global) || tmr_done) begin
                  state_reg        <= S_IDLE;
                  polling_reg      <= 1'b0;
                  suspend_wait_reg <= 1'b0;
               end else begin
                  state_reg <= S_RD_GAP;
               end
            end
            S_RD_GAP: begin
               state_reg <= S_RD_LOW;
            end
            S_RST_LOW: begin
               if (tmr_done) begin
                  state_reg <= S_RST_WAIT;
               end
            end
            S_RST_WAIT: begin
               // reset line is released; wait for the worst-case completion
               if (tmr_done) begin
                  state_reg <= S_RECOVER;
                  step_reg  <= '0;
               end
            end
            default: state_reg <= S_POWERUP;
         endcase
      end
   end

   // pins, all from flip-flops
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pins <= '{rst_n: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0,
                     dq_out: '0, dq_oe: 1'b1};
      end else begin
         o_pins.rst_n <= !(state_reg == S_POWERUP ||
                           (state_reg == S_IDLE && accept && i_req.op == FRSS_OP_RESET) ||
                           (state_reg == S_RST_LOW && !tmr_done));
         // both strobes fall together and rise together
         o_pins.ce_n  <= !(state_reg == S_IDLE && accept && i_req.op != FRSS_OP_RESET &&
                           i_req.op != FRSS_OP_NONE) && !(state_reg == S_RD_GAP) &&
                         !(state_reg == S_WR_HIGH && (polling_reg || suspend_wait_reg)) &&
                         !(state_reg == S_RD_LOW);
         o_pins.we_n  <= !(state_reg == S_IDLE && accept && i_req.op != FRSS_OP_RESET &&
                           i_req.op != FRSS_OP_NONE);
         o_pins.oe_n  <= !(state_reg == S_RD_GAP ||
                           (state_reg == S_WR_HIGH && (polling_reg || suspend_wait_reg)) ||
                           state_reg == S_RD_LOW);
         if (state_reg == S_IDLE && accept) begin
            o_pins.addr <= i_req.addr;
            case (i_req.op)
               FRSS_OP_SUSPEND_PGM,
               FRSS_OP_SUSPEND_ERS: o_pins.dq_out <= `FRSS_CMD_SUSPEND;
               FRSS_OP_RESUME:      o_pins.dq_out <= `FRSS_CMD_RESUME;
               FRSS_OP_POLL:        o_pins.dq_out <= `FRSS_CMD_READ_STATUS;
               default:             o_pins.dq_out <= i_req.data;
            endcase
         end
         // drive data only during the write low phase (enable is active low)
         o_pins.dq_oe <= !(state_reg == S_IDLE && accept && i_req.op != FRSS_OP_RESET &&
                           i_req.op != FRSS_OP_NONE);
      end
   end

   // user answers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_req_ready <= 1'b0;
         o_done      <= 1'b0;
         o_timeout   <= 1'b0;
         o_status    <= '0;
      end else begin
         o_req_ready <= (state_reg == S_IDLE) && !accept;
         o_done      <= 1'b0;
         o_timeout   <= 1'b0;
         if (state_reg == S_RD_SAMPLE) begin
            o_status <= i_dq;
            if (ready_of(i_dq, req_reg.use_global)) begin
               o_done <= 1'b1;
            end else if (tmr_done) begin
               o_done    <= 1'b1;
               o_timeout <= 1'b1;
            end
         end else if ((state_reg == S_WR_HIGH && !polling_reg && !suspend_wait_reg) ||
                      (state_reg == S_RST_WAIT && tmr_done)) begin
            o_done <= 1'b1;
         end
      end
   end
endmodule : frss_ctrl
`default_nettype wire

// [hdl/frss_consts.svh]
// frss_consts.svh: timing counts, command codes and status bit positions
// assumes a 20 MHz controller clock (50 ns period)
`ifndef FRSS_CONSTS_SVH
`define FRSS_CONSTS_SVH

`define FRSS_CLK_NS            50
// reset low time in ns, and cycles rounded up
`define FRSS_RST_LOW_NS        100
`define FRSS_RST_LOW_CYC       ((`FRSS_RST_LOW_NS + `FRSS_CLK_NS - 1) / `FRSS_CLK_NS)
// worst-case reset completion during erase/program, in us
`define FRSS_RST_DONE_US       22
`define FRSS_RST_DONE_CYC      ((`FRSS_RST_DONE_US * 1000 + `FRSS_CLK_NS - 1) / `FRSS_CLK_NS)
// recovery after reset release before reads or writes, in ns
`define FRSS_RECOVER_NS        150
`define FRSS_RECOVER_CYC       ((`FRSS_RECOVER_NS + `FRSS_CLK_NS - 1) / `FRSS_CLK_NS)
// suspend latencies, in us
`define FRSS_PGM_SUSP_US       10
`define FRSS_PGM_SUSP_CYC      ((`FRSS_PGM_SUSP_US * 1000) / `FRSS_CLK_NS)
`define FRSS_ERS_SUSP_US       20
`define FRSS_ERS_SUSP_CYC      ((`FRSS_ERS_SUSP_US * 1000) / `FRSS_CLK_NS)
// least resume-to-suspend spacing, in us
`define FRSS_RESUME_GAP_US     500
`define FRSS_RESUME_GAP_CYC    ((`FRSS_RESUME_GAP_US * 1000 + `FRSS_CLK_NS - 1) / `FRSS_CLK_NS)
// completion limits, in s
`define FRSS_PARAM_ERS_S       4
`define FRSS_MAIN_ERS_S        5
`define FRSS_CHIP_ERS_S        350
`define FRSS_CYC_PER_S         20000000
// strobe timing: low pulse and high gap, in cycles (50 ns and 20 ns min)
`define FRSS_WR_LOW_CYC        1
`define FRSS_WR_HIGH_CYC       1
// status word bit positions
`define FRSS_BIT_PART_READY    7
`define FRSS_BIT_GLOBAL_READY  15
// command codes (read status, suspend, resume)
`define FRSS_CMD_READ_STATUS   16'h0070
`define FRSS_CMD_SUSPEND       16'h00b0
`define FRSS_CMD_RESUME        16'h00d0

`endif

// [hdl/frss_pkg.sv]
// frss_pkg: types shared by the flash reset/suspend/status controller
// assumes frss_consts.svh for all numeric values
`default_nettype none
package frss_pkg;
   typedef enum logic [2:0] {
      FRSS_OP_NONE,
      FRSS_OP_WRITE,
      FRSS_OP_SUSPEND_PGM,
      FRSS_OP_SUSPEND_ERS,
      FRSS_OP_RESUME,
      FRSS_OP_POLL,
      FRSS_OP_RESET
   } frss_op_type;

   typedef enum logic [1:0] {
      FRSS_WAIT_PARAM_ERS,
      FRSS_WAIT_MAIN_ERS,
      FRSS_WAIT_CHIP_ERS,
      FRSS_WAIT_PROGRAM
   } frss_wait_type;

   // user request
   typedef struct packed {
      frss_op_type   op;
      frss_wait_type wait_kind;
      logic          use_global;
      logic [20:0]   addr;
      logic [15:0]   data;
   } frss_req_type;

   // flash pins driven by the controller
   typedef struct packed {
      logic        rst_n;
      logic        ce_n;
      logic        we_n;
      logic        oe_n;
      logic [20:0] addr;
      logic [15:0] dq_out;
      logic        dq_oe;
   } frss_pins_type;
endpackage : frss_pkg
`default_nettype wire

// [hdl/frss_timer.sv]
// frss_timer: loadable down counter with a done flag
// assumes load is a one-cycle pulse; width fits the longest count
`include "frss_consts.svh"
`default_nettype none
module frss_timer #(
   parameter int WIDTH = 34
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // control
   input  wire logic             i_load,
   input  wire logic [WIDTH-1:0] i_count,
   // status
   output logic                  o_done
);
   logic [WIDTH-1:0] count_reg;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         count_reg <= '0;
      end else if (i_load) begin
         count_reg <= i_count;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - 1'b1;
      end
   end

   // done stays low during the load cycle itself
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_done <= 1'b1;
      end else if (i_load) begin
         o_done <= 1'b0;
      end else begin
         o_done <= (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1});
      end
   end
endmodule : frss_timer
`default_nettype wire

// [verification/frss_ctrl_chk.sv]
// frss_ctrl_chk: pin-level and done/timeout assertions for the flash controller
// assumes a bind into frss_ctrl and one clock domain
`include "frss_consts.svh"
`default_nettype none
module frss_ctrl_chk #(
   parameter longint RESUME_GAP_CYC = 50
) (
   // clock and reset
   input wire logic                    i_clk,
   input wire logic                    i_rst,
   // watched outputs
   input wire logic                    o_done,
   input wire logic                    o_timeout,
   input wire frss_pkg::frss_pins_type o_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   import frss_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // cycles since the last resume strobe, saturating
   longint gap_reg;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst)
         gap_reg <= RESUME_GAP_CYC;
      else if ($fell(o_pins.we_n) && o_pins.dq_out == `FRSS_CMD_RESUME)
         gap_reg <= 0;
      else if (gap_reg < RESUME_GAP_CYC)
         gap_reg <= gap_reg + 1;
   end
   a_reset_pulse_min: assert property ($fell(o_pins.rst_n) |-> !o_pins.rst_n [*2])
      else $error("flash reset pulse too short");
   a_powerup_hold: assert property ($fell(i_rst) |-> !o_pins.rst_n [*2])
      else $error("power-up reset hold too short");
   a_recovery_quiet: assert property ($rose(o_pins.rst_n) |-> o_pins.we_n [*3])
      else $error("write strobe inside reset recovery");
   a_reset_no_write: assert property (!o_pins.rst_n |-> o_pins.we_n && o_pins.dq_oe)
      else $error("bus driven while flash in reset");
   a_write_pulse: assert property ($fell(o_pins.we_n) |->
      !o_pins.ce_n && !o_pins.dq_oe ##1 o_pins.we_n)
      else $error("write strobe framing wrong");
   a_read_bus_free: assert property (!o_pins.oe_n |-> o_pins.dq_oe && o_pins.we_n)
      else $error("data driven during status read");
   a_resume_gap: assert property ($fell(o_pins.we_n) &&
      o_pins.dq_out == `FRSS_CMD_SUSPEND |-> gap_reg >= RESUME_GAP_CYC - 1)
      else $error("suspend too soon after resume");
   a_timeout_done: assert property (o_timeout |-> o_done)
      else $error("timeout without done");
endmodule : frss_ctrl_chk
bind frss_ctrl frss_ctrl_chk #(.RESUME_GAP_CYC(RESUME_GAP_CYC)) chk_u (.i_clk(i_clk),
   .i_rst(i_rst), .o_done(o_done), .o_timeout(o_timeout), .o_pins(o_pins));
`default_nettype wire

// [verification/frss_flash_model.sv]
// frss_flash_model: behavioural flash that answers status reads
// assumes the bench starts an operation by raising i_start
`include "frss_consts.svh"
`default_nettype none
module frss_flash_model (
   // controller pins
   input  wire frss_pkg::frss_pins_type i_pins,
   // operation set-up from the bench
   input  wire logic                    i_start,
   input  wire logic                    i_other,
   input  wire logic [31:0]             i_op_ns,
   input  wire logic [31:0]             i_sus_ns,
   // data bus and last written word
   output logic [15:0]                  o_dq,
   output logic [15:0]                  o_last_wr
);
   timeunit 1ns;
   timeprecision 1ps;
   import frss_pkg::*;
   realtime     busy_until = 0, valid_at = 0;
   logic        other_reg = 1'b0, sus_reg = 1'b0, wr_open = 1'b0, busy;
   logic [15:0] dq_reg = 16'h5a5a;
   assign o_dq = dq_reg;
   always @(posedge i_start) begin
      busy_until = $realtime + i_op_ns;
      other_reg = i_other;
   end
   // earlier rising strobe closes the write
   always @(i_pins.we_n or i_pins.ce_n) begin
      if (wr_open && i_pins.rst_n) begin
         o_last_wr = i_pins.dq_out;
         if (i_pins.dq_out == `FRSS_CMD_SUSPEND && $realtime < busy_until) begin
            busy_until = $realtime + i_sus_ns;
            sus_reg = 1'b1;
         end
         if (i_pins.dq_out == `FRSS_CMD_RESUME && sus_reg) begin
            busy_until = $realtime + i_op_ns;
            sus_reg = 1'b0;
         end
      end
      wr_open = !i_pins.we_n && !i_pins.ce_n;
   end
   // abort at once, so reset ends inside both limits
   always @(negedge i_pins.rst_n) busy_until = $realtime;
   always @(posedge i_pins.rst_n) valid_at = $realtime + 150;
   // unselected bus toggles so a stale value never passes
   always begin
      #5;
      busy = $realtime < busy_until;
      if (i_pins.rst_n && !i_pins.ce_n && !i_pins.oe_n && $realtime >= valid_at)
         dq_reg = {!busy, 7'h00, !busy || other_reg, 7'h00};
      else
         dq_reg = ~dq_reg;
   end
endmodule : frss_flash_model
`default_nettype wire

// [verification/frss_ctrl_tb.sv]
// frss_ctrl_tb: self-checking bench for the flash controller
// assumes frss_flash_model on the pins and frss_ctrl_chk bound in
`default_nettype none
module frss_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import frss_pkg::*;
   typedef struct {
      frss_op_type   op;
      frss_wait_type wk;
      logic          glob, other;
      int            op_ns, sus_ns;
      logic          to;
      logic [15:0]   st;
   } frss_row_type;
   // short wait limits keep the run brief; suspend limits stay full
   localparam longint LIM = 50;
   frss_row_type rows [8] = '{
      '{FRSS_OP_POLL, FRSS_WAIT_PARAM_ERS, 0, 0, 1000, 0, 0, 16'h8080},
      '{FRSS_OP_POLL, FRSS_WAIT_MAIN_ERS, 0, 0, 5000, 0, 1, 16'h0000},
      '{FRSS_OP_POLL, FRSS_WAIT_CHIP_ERS, 1, 0, 1500, 0, 0, 16'h8080},
      '{FRSS_OP_POLL, FRSS_WAIT_PROGRAM, 0, 1, 1500, 0, 0, 16'h0080},
      '{FRSS_OP_POLL, FRSS_WAIT_PROGRAM, 1, 1, 1500, 0, 0, 16'h8080},
      '{FRSS_OP_SUSPEND_PGM, FRSS_WAIT_PROGRAM, 0, 0, 99000, 5000, 0, 16'h8080},
      '{FRSS_OP_SUSPEND_PGM, FRSS_WAIT_PROGRAM, 0, 0, 99000, 15000, 1, 16'h0000},
      '{FRSS_OP_SUSPEND_ERS, FRSS_WAIT_MAIN_ERS, 0, 0, 99000, 15000, 0, 16'h8080}};
   logic          i_clk = 1'b0;
   logic          i_rst, req_valid, o_req_ready, o_done, o_timeout, start, other, to_seen;
   frss_req_type  req;
   frss_pins_type o_pins;
   logic [15:0]   o_status, model_dq, last_wr, dq_bus, st_seen;
   int            op_ns, sus_ns, n_cyc, checked, n_errors, cyc_cnt = 0;
   always #25 i_clk = ~i_clk;
   frss_ctrl #(.PARAM_ERS_CYC(LIM), .MAIN_ERS_CYC(LIM), .CHIP_ERS_CYC(LIM),
      .PROGRAM_CYC(LIM), .RST_DONE_CYC(LIM), .RESUME_GAP_CYC(LIM)) dut_u (
      .i_clk(i_clk), .i_rst(i_rst), .i_req_valid(req_valid), .i_req(req),
      .o_req_ready(o_req_ready), .o_done(o_done), .o_timeout(o_timeout),
      .o_status(o_status), .o_pins(o_pins), .i_dq(dq_bus));
   frss_flash_model model_u (.i_pins(o_pins), .i_start(start), .i_other(other),
      .i_op_ns(op_ns), .i_sus_ns(sus_ns), .o_dq(model_dq), .o_last_wr(last_wr));
   assign dq_bus = o_pins.dq_oe ? model_dq : o_pins.dq_out;
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task automatic arm(input int ons, input int sns, input logic oth);
      @(posedge i_clk);
      op_ns <= ons;
      sus_ns <= sns;
      other <= oth;
      @(posedge i_clk);
      start <= 1'b1;
      @(posedge i_clk);
      start <= 1'b0;
   endtask : arm
   task automatic issue(input frss_op_type op, input frss_wait_type wk, input logic g,
                        input logic [15:0] d);
      n_cyc = 0;
      while (o_req_ready !== 1'b1 && n_cyc < 2000) begin
         @(posedge i_clk);
         #1 n_cyc++;
      end
      @(posedge i_clk);
      req_valid <= 1'b1;
      req <= '{op: op, wait_kind: wk, use_global: g, addr: 21'h000000, data: d};
      // an erase suspend inside the resume gap is held off, so keep asking
      do begin
         @(posedge i_clk);
         #1 n_cyc++;
      end while (o_req_ready === 1'b1 && n_cyc < 2000);
      @(posedge i_clk);
      req_valid <= 1'b0;
      while (o_done !== 1'b1 && n_cyc < 2000) begin
         @(posedge i_clk);
         #1 n_cyc++;
      end
      check("done", 16'(o_done), 16'h0001);
      to_seen = o_timeout;
      st_seen = o_status;
   endtask : issue
   always @(posedge i_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         n_errors++;
         print_verdict();
      end
   end
   initial begin
      i_rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      start = 1'b0;
      other = 1'b0;
      op_ns = 0;
      sus_ns = 0;
      checked = 0;
      n_errors = 0;
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      foreach (rows[i]) begin
         arm(rows[i].op_ns, rows[i].sus_ns, rows[i].other);
         issue(rows[i].op, rows[i].wk, rows[i].glob, 16'h0000);
         check("timeout", 16'(to_seen), 16'(rows[i].to));
         check("status", st_seen, rows[i].st);
      end
      issue(FRSS_OP_WRITE, FRSS_WAIT_PROGRAM, 1'b0, 16'h0040);
      check("written word", last_wr, 16'h0040);
      // short suspend latency, so only the resume gap can hold it back
      arm(99000, 100, 1'b0);
      issue(FRSS_OP_SUSPEND_ERS, FRSS_WAIT_MAIN_ERS, 1'b0, 16'h0000);
      issue(FRSS_OP_RESUME, FRSS_WAIT_MAIN_ERS, 1'b0, 16'h0000);
      issue(FRSS_OP_SUSPEND_ERS, FRSS_WAIT_MAIN_ERS, 1'b0, 16'h0000);
      check("resume gap", 16'(n_cyc >= LIM - 2), 16'h0001);
      check("status", st_seen, 16'h8080);
      arm(99000, 100, 1'b0);
      issue(FRSS_OP_RESET, FRSS_WAIT_MAIN_ERS, 1'b0, 16'h0000);
      check("reset wait", 16'(n_cyc >= LIM), 16'h0001);
      issue(FRSS_OP_POLL, FRSS_WAIT_PARAM_ERS, 1'b0, 16'h0000);
      check("status", st_seen, 16'h8080);
      // controller reset in the middle of a poll
      arm(99000, 100, 1'b0);
      req_valid <= 1'b1;
      req <= '{op: FRSS_OP_POLL, wait_kind: FRSS_WAIT_CHIP_ERS, use_global: 1'b1,
               addr: 21'h000000, data: 16'h0000};
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b1;
      req_valid <= 1'b0;
      #1 check("reset pins", 16'({o_pins.rst_n, o_pins.we_n, o_pins.dq_oe, o_req_ready}),
               16'h0006);
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      issue(FRSS_OP_POLL, FRSS_WAIT_PARAM_ERS, 1'b0, 16'h0000);
      check("status", st_seen, 16'h8080);
      print_verdict();
   end
endmodule : frss_ctrl_tb
`default_nettype wire
